// *** src/fpc_pkg.sv ***
// Constants and types shared by the flash program controller files
package fpc_pkg;

  localparam int REG_SEL_W = 4;
  localparam int FLASH_AW = 15;
  localparam int DATA_W = 16;
  localparam int PAGE_WORDS = 128;
  localparam int PAGE_IDX_W = 7;
  localparam int DATA_WORDS = 4;

  localparam logic [REG_SEL_W-1:0] SEL_MAIN_CTRL = 4'h0;
  localparam logic [REG_SEL_W-1:0] SEL_CHIP_RESET_KEY = 4'h1;
  localparam logic [REG_SEL_W-1:0] SEL_BUF_CLEAR = 4'h2;
  localparam logic [REG_SEL_W-1:0] SEL_ADDR_LOW = 4'h3;
  localparam logic [REG_SEL_W-1:0] SEL_ADDR_HIGH = 4'h4;
  // Word n low byte sits at SEL_DATA_BASE + 2n, its high byte one above
  localparam logic [REG_SEL_W-1:0] SEL_DATA_BASE = 4'h5;

  localparam int MC_ENABLED_BIT = 7;
  localparam int MC_MODE_MSB = 6;
  localparam int MC_MODE_LSB = 4;
  localparam int MC_UNLOCK_BIT = 3;
  localparam int MC_WRITE_BIT = 2;
  localparam int MC_RDEN_BIT = 1;
  localparam int MC_READ_BIT = 0;
  localparam int CLR_BIT = 0;

  localparam logic [2:0] MODE_WRITE = 3'h0;
  localparam logic [2:0] MODE_ERASE = 3'h1;
  localparam logic [2:0] MODE_READ = 3'h3;
  localparam logic [2:0] MODE_UNLOCK = 3'h6;

  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] CHIP_RESET_VALUE = 8'h55;

  localparam logic [7:0] KEY_W1_LO = 8'h00;
  localparam logic [7:0] KEY_W2_LO = 8'h0d;
  localparam logic [7:0] KEY_W3_LO = 8'hc3;
  localparam logic [7:0] KEY_W1_HI = 8'h04;
  localparam logic [7:0] KEY_W2_HI = 8'h09;
  localparam logic [7:0] KEY_W3_HI = 8'h40;

  localparam int CLK_PERIOD_NS = 8;
  localparam int UNLOCK_WINDOW_NS = 2000;
  localparam int UNLOCK_CYCLES = UNLOCK_WINDOW_NS / CLK_PERIOD_NS;
  localparam int TIMER_W = 12;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_ERASE,
    ST_SCAN,
    ST_PROG
  } fpc_state_t;

endpackage

// *** src/fpc_wbuf.sv ***
// Page write buffer: flip-flop word store with a valid bit per word
module fpc_wbuf #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 128,
  parameter int IW    = $clog2(DEPTH)
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic             wr_in,
  input  wire logic [IW-1:0]    wr_idx_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             clr_in,
  input  wire logic [IW-1:0]    rd_idx_in,
  output logic      [WIDTH-1:0] rd_data_out,
  output logic                  rd_valid_out
);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [DEPTH-1:0] valid_r;

  always_ff @(posedge clk_in) begin
    if (wr_in) begin
      mem_r[wr_idx_in] <= wr_data_in;
    end
  end

  // A word loaded during a clear survives it
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      valid_r <= '0;
    end else begin
      if (clr_in) begin
        valid_r <= '0;
      end
      if (wr_in) begin
        valid_r[wr_idx_in] <= 1'b1;
      end
    end
  end

  assign rd_data_out  = mem_r[rd_idx_in];
  assign rd_valid_out = valid_r[rd_idx_in];

endmodule

// *** src/fpc_ctrl.sv ***
// Flash program controller: control registers, unlock window, page buffer loading and flash sequencing
module fpc_ctrl
  import fpc_pkg::*;
#(
  parameter int UNLOCK_WINDOW_CYCLES = fpc_pkg::UNLOCK_CYCLES,
  parameter int WORDS                = fpc_pkg::PAGE_WORDS
) (
  input  wire logic                          clk_in,
  input  wire logic                          rst_in,
  input  wire logic [fpc_pkg::REG_SEL_W-1:0] reg_sel_in,
  input  wire logic                          reg_wr_in,
  input  wire logic                          reg_rd_in,
  input  wire logic [7:0]                    reg_wdata_in,
  output logic      [7:0]                    reg_rdata_out,
  output logic                               cpu_stall_out,
  output logic                               chip_reset_out,
  output logic      [fpc_pkg::FLASH_AW-1:0]  flash_addr_out,
  output logic      [fpc_pkg::DATA_W-1:0]    flash_wdata_out,
  output logic                               flash_read_out,
  output logic                               flash_prog_out,
  output logic                               flash_erase_out,
  input  wire logic [fpc_pkg::DATA_W-1:0]    flash_rdata_in,
  input  wire logic                          flash_done_in
);

  import fpc_pkg::*;

  localparam logic [PAGE_IDX_W-1:0] LAST_IDX = PAGE_IDX_W'(WORDS - 1);

  fpc_state_t            state_r;
  logic                  enabled_r;
  logic [2:0]            mode_r;
  logic                  unlock_r;
  logic                  write_r;
  logic                  rden_r;
  logic                  read_r;
  logic [7:0]            reset_key_r;
  logic                  clr_r;
  logic [FLASH_AW-1:0]   addr_r;
  logic [7:0]            data_lo_r [DATA_WORDS];
  logic [7:0]            data_hi_r [DATA_WORDS];
  logic [5:0]            key_seen_r;
  logic [TIMER_W-1:0]    timer_r;
  logic [PAGE_IDX_W-1:0] idx_r;
  logic [7:0]            rdata_r;
  logic                  chip_reset_r;

  logic                  mc_wr;
  logic                  load_word;
  logic                  unlock_start;
  logic                  unlock_expire;
  logic                  key_ok;
  logic                  write_go;
  logic                  write_legal;
  logic                  read_go;
  logic                  read_legal;
  logic                  write_done;
  logic                  read_done;
  logic                  prog_finish;
  logic                  buf_clr;
  logic [DATA_W-1:0]     buf_data;
  logic                  buf_valid;

  function automatic logic wr_hit(input logic [REG_SEL_W-1:0] sel);
    wr_hit = reg_wr_in && (reg_sel_in == sel);
  endfunction

  function automatic logic [REG_SEL_W-1:0] lo_sel(input int n);
    lo_sel = SEL_DATA_BASE + REG_SEL_W'(2 * n);
  endfunction

  function automatic logic [REG_SEL_W-1:0] hi_sel(input int n);
    hi_sel = SEL_DATA_BASE + REG_SEL_W'(2 * n + 1);
  endfunction

  assign mc_wr        = reg_wr_in && (reg_sel_in == SEL_MAIN_CTRL);
  assign load_word    = reg_wr_in && (reg_sel_in == hi_sel(0));
  assign unlock_start = mc_wr && reg_wdata_in[MC_UNLOCK_BIT];

  // Unlock window timer and key tracking; a fresh trigger restarts the window
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      unlock_r   <= 1'b0;
      timer_r    <= '0;
      key_seen_r <= '0;
    end else if (unlock_start) begin
      unlock_r   <= 1'b1;
      timer_r    <= TIMER_W'(UNLOCK_WINDOW_CYCLES - 1);
      key_seen_r <= '0;
    end else if (unlock_r) begin
      if (timer_r == '0) begin
        unlock_r <= 1'b0;
      end else begin
        timer_r <= timer_r - TIMER_W'(1);
      end
      for (int n = 1; n < DATA_WORDS; n++) begin
        if (wr_hit(lo_sel(n))) begin
          key_seen_r[n-1] <= 1'b1;
        end
        if (wr_hit(hi_sel(n))) begin
          key_seen_r[n+2] <= 1'b1;
        end
      end
    end
  end

  assign unlock_expire = unlock_r && (timer_r == '0) && !unlock_start;

  // Bytes written before the window opened do not count toward the key
  assign key_ok = (key_seen_r == 6'h3f) && (mode_r == MODE_UNLOCK)
                  && (data_lo_r[1] == KEY_W1_LO) && (data_lo_r[2] == KEY_W2_LO)
                  && (data_lo_r[3] == KEY_W3_LO) && (data_hi_r[1] == KEY_W1_HI)
                  && (data_hi_r[2] == KEY_W2_HI) && (data_hi_r[3] == KEY_W3_HI);

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      enabled_r <= 1'b0;
    end else if (unlock_expire && key_ok) begin
      enabled_r <= 1'b1;
    end else if (mc_wr && !reg_wdata_in[MC_ENABLED_BIT]) begin
      enabled_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mode_r <= MODE_WRITE;
      rden_r <= 1'b0;
    end else if (mc_wr) begin
      mode_r <= reg_wdata_in[MC_MODE_MSB:MC_MODE_LSB];
      rden_r <= reg_wdata_in[MC_RDEN_BIT];
    end
  end

  // Triggers are set by software only and cleared by hardware only
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      write_r <= 1'b0;
    end else if (mc_wr && reg_wdata_in[MC_WRITE_BIT]) begin
      write_r <= 1'b1;
    end else if (write_done) begin
      write_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      read_r <= 1'b0;
    end else if (mc_wr && reg_wdata_in[MC_READ_BIT]) begin
      read_r <= 1'b1;
    end else if (read_done) begin
      read_r <= 1'b0;
    end
  end

  assign cpu_stall_out = write_r || read_r;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      reset_key_r  <= BYTE_RESET;
      chip_reset_r <= 1'b0;
    end else begin
      chip_reset_r <= wr_hit(SEL_CHIP_RESET_KEY) && (reg_wdata_in == CHIP_RESET_VALUE);
      if (wr_hit(SEL_CHIP_RESET_KEY)) begin
        reset_key_r <= reg_wdata_in;
      end
    end
  end

  assign chip_reset_out = chip_reset_r;

  // Clear takes one cycle; a new request in that cycle keeps the bit set
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      clr_r <= 1'b0;
    end else if (wr_hit(SEL_BUF_CLEAR) && reg_wdata_in[CLR_BIT]) begin
      clr_r <= 1'b1;
    end else if (clr_r) begin
      clr_r <= 1'b0;
    end
  end

  // The address walks only inside the page so the buffer never spills
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      addr_r <= '0;
    end else if (wr_hit(SEL_ADDR_LOW)) begin
      addr_r[7:0] <= reg_wdata_in;
    end else if (wr_hit(SEL_ADDR_HIGH)) begin
      addr_r[FLASH_AW-1:8] <= reg_wdata_in[FLASH_AW-9:0];
    end else if (load_word && (addr_r[PAGE_IDX_W-1:0] != LAST_IDX)) begin
      addr_r[PAGE_IDX_W-1:0] <= addr_r[PAGE_IDX_W-1:0] + PAGE_IDX_W'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      for (int n = 0; n < DATA_WORDS; n++) begin
        data_lo_r[n] <= BYTE_RESET;
        data_hi_r[n] <= BYTE_RESET;
      end
    end else if (state_r == ST_READ && flash_done_in) begin
      data_lo_r[0] <= flash_rdata_in[7:0];
      data_hi_r[0] <= flash_rdata_in[DATA_W-1:8];
    end else begin
      for (int n = 0; n < DATA_WORDS; n++) begin
        if (wr_hit(lo_sel(n))) begin
          data_lo_r[n] <= reg_wdata_in;
        end
        if (wr_hit(hi_sel(n))) begin
          data_hi_r[n] <= reg_wdata_in;
        end
      end
    end
  end

  assign write_go    = (state_r == ST_IDLE) && write_r;
  assign write_legal = enabled_r && ((mode_r == MODE_WRITE) || (mode_r == MODE_ERASE));
  assign read_go     = (state_r == ST_IDLE) && !write_r && read_r;
  assign read_legal  = rden_r && (mode_r == MODE_READ);

  assign prog_finish = ((state_r == ST_SCAN) && !buf_valid && (idx_r == LAST_IDX))
                       || ((state_r == ST_PROG) && flash_done_in && (idx_r == LAST_IDX));
  assign write_done  = (write_go && !write_legal)
                       || ((state_r == ST_ERASE) && flash_done_in) || prog_finish;
  assign read_done   = (read_go && !read_legal) || ((state_r == ST_READ) && flash_done_in);
  assign buf_clr     = clr_r || prog_finish;

  fpc_wbuf #(
    .WIDTH (DATA_W),
    .DEPTH (WORDS),
    .IW    (PAGE_IDX_W)
  ) u_wbuf (
    .clk_in       (clk_in),
    .rst_in       (rst_in),
    .wr_in        (load_word),
    .wr_idx_in    (addr_r[PAGE_IDX_W-1:0]),
    .wr_data_in   ({reg_wdata_in, data_lo_r[0]}),
    .clr_in       (buf_clr),
    .rd_idx_in    (idx_r),
    .rd_data_out  (buf_data),
    .rd_valid_out (buf_valid)
  );

  // Flash sequencer; strobes stay high until the array reports done
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_r         <= ST_IDLE;
      idx_r           <= '0;
      flash_addr_out  <= '0;
      flash_wdata_out <= '0;
      flash_read_out  <= 1'b0;
      flash_prog_out  <= 1'b0;
      flash_erase_out <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (write_go && write_legal) begin
            if (mode_r == MODE_ERASE) begin
              flash_addr_out  <= {addr_r[FLASH_AW-1:PAGE_IDX_W], PAGE_IDX_W'(0)};
              flash_erase_out <= 1'b1;
              state_r         <= ST_ERASE;
            end else begin
              idx_r   <= '0;
              state_r <= ST_SCAN;
            end
          end else if (read_go && read_legal) begin
            flash_addr_out <= addr_r;
            flash_read_out <= 1'b1;
            state_r        <= ST_READ;
          end
        end
        ST_READ: begin
          if (flash_done_in) begin
            flash_read_out <= 1'b0;
            state_r        <= ST_IDLE;
          end
        end
        ST_ERASE: begin
          if (flash_done_in) begin
            flash_erase_out <= 1'b0;
            state_r         <= ST_IDLE;
          end
        end
        ST_SCAN: begin
          if (buf_valid) begin
            flash_addr_out  <= {addr_r[FLASH_AW-1:PAGE_IDX_W], idx_r};
            flash_wdata_out <= buf_data;
            flash_prog_out  <= 1'b1;
            state_r         <= ST_PROG;
          end else if (idx_r == LAST_IDX) begin
            state_r <= ST_IDLE;
          end else begin
            idx_r <= idx_r + PAGE_IDX_W'(1);
          end
        end
        ST_PROG: begin
          if (flash_done_in) begin
            flash_prog_out <= 1'b0;
            if (idx_r == LAST_IDX) begin
              state_r <= ST_IDLE;
            end else begin
              idx_r   <= idx_r + PAGE_IDX_W'(1);
              state_r <= ST_SCAN;
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  function automatic logic [7:0] read_mux(input logic [REG_SEL_W-1:0] sel);
    read_mux = 8'h00;
    case (sel)
      SEL_MAIN_CTRL:      read_mux = {enabled_r, mode_r, unlock_r, write_r, rden_r, read_r};
      SEL_CHIP_RESET_KEY: read_mux = reset_key_r;
      SEL_BUF_CLEAR:      read_mux = {7'h00, clr_r};
      SEL_ADDR_LOW:       read_mux = addr_r[7:0];
      SEL_ADDR_HIGH:      read_mux = {1'b0, addr_r[FLASH_AW-1:8]};
      default: begin
        for (int n = 0; n < DATA_WORDS; n++) begin
          if (sel == lo_sel(n)) begin
            read_mux = data_lo_r[n];
          end
          if (sel == hi_sel(n)) begin
            read_mux = data_hi_r[n];
          end
        end
      end
    endcase
  endfunction

  // Read data is held until the next read strobe
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_r <= 8'h00;
    end else if (reg_rd_in) begin
      rdata_r <= read_mux(reg_sel_in);
    end
  end

  assign reg_rdata_out = rdata_r;

endmodule

// *** sim/fpc_flash_model.sv ***
// Behavioural flash array answering the controller strobes after a chosen delay
module fpc_flash_model (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        rd_in,
  input  wire logic        prog_in,
  input  wire logic        erase_in,
  input  wire logic [14:0] addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic [3:0]  delay_in,
  output logic      [15:0] rdata_out = 16'h0000,
  output logic             done_out = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [int];
  int          cnt;
  // Data lines keep toggling outside an answer so a stale word is never taken
  always @(posedge clk_in) begin
    done_out <= 1'b0;
    rdata_out <= ~rdata_out;
    if (rst_in) begin
      cnt <= 0;
    end else if ((rd_in | prog_in | erase_in) && !done_out) begin
      cnt <= cnt + 1;
      if (cnt >= delay_in) begin
        cnt <= 0;
        done_out <= 1'b1;
        if (rd_in) rdata_out <= mem.exists(addr_in) ? mem[addr_in] : 16'hffff;
        if (prog_in) mem[addr_in] = wdata_in;
        if (erase_in) for (int i = 0; i < 128; i++) mem[{addr_in[14:7], i[6:0]}] = 16'h0000;
      end
    end
  end
endmodule

// *** sim/fpc_ctrl_checker.sv ***
// Port checks for the flash program controller
module fpc_ctrl_checker
  import fpc_pkg::*;
(
  input wire logic                          clk_in,
  input wire logic                          rst_in,
  input wire logic [fpc_pkg::REG_SEL_W-1:0] reg_sel_in,
  input wire logic                          reg_wr_in,
  input wire logic                          reg_rd_in,
  input wire logic [7:0]                    reg_wdata_in,
  input wire logic [7:0]                    reg_rdata_out,
  input wire logic                          cpu_stall_out,
  input wire logic                          chip_reset_out,
  input wire logic [fpc_pkg::FLASH_AW-1:0]  flash_addr_out,
  input wire logic [fpc_pkg::DATA_W-1:0]    flash_wdata_out,
  input wire logic                          flash_read_out,
  input wire logic                          flash_prog_out,
  input wire logic                          flash_erase_out,
  input wire logic [fpc_pkg::DATA_W-1:0]    flash_rdata_in,
  input wire logic                          flash_done_in
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic any_strobe;
  assign any_strobe = flash_read_out | flash_prog_out | flash_erase_out;
  stall_cover_a: assert property (any_strobe |-> cpu_stall_out)
    else $error("flash strobe without cpu stall");
  stall_onset_a: assert property (reg_wr_in && reg_sel_in == SEL_MAIN_CTRL && !cpu_stall_out
    && (reg_wdata_in[MC_WRITE_BIT] || reg_wdata_in[MC_READ_BIT]) |=> cpu_stall_out)
    else $error("trigger write did not stall");
  reset_key_a: assert property (1'b1 |=> chip_reset_out == $past(reg_wr_in
    && reg_sel_in == SEL_CHIP_RESET_KEY && reg_wdata_in == CHIP_RESET_VALUE))
    else $error("chip reset pulse mismatch");
  erase_page_a: assert property (flash_erase_out |-> flash_addr_out[6:0] == 7'h00)
    else $error("erase address not page aligned");
  prog_hold_a: assert property (flash_prog_out && !flash_done_in
    |=> flash_prog_out && $stable(flash_addr_out) && $stable(flash_wdata_out))
    else $error("program strobe changed before done");
  strobe_end_a: assert property (any_strobe && flash_done_in |=> !any_strobe)
    else $error("strobe held after done");
  stall_drop_a: assert property ((flash_erase_out || flash_read_out) && flash_done_in
    |=> !cpu_stall_out)
    else $error("stall held after erase or read");
  clear_read_a: assert property (reg_rd_in && reg_sel_in == SEL_BUF_CLEAR |=> reg_rdata_out[7:1] == 7'h00)
    else $error("buffer clear upper bits not zero");
  erase_seen_c: cover property (flash_erase_out && flash_done_in);
  prog_seen_c: cover property (flash_prog_out && flash_done_in);
  reset_seen_c: cover property (chip_reset_out);
endmodule
bind fpc_ctrl fpc_ctrl_checker fpc_ctrl_checker_inst (.clk_in, .rst_in, .reg_sel_in, .reg_wr_in, .reg_rd_in,
  .reg_wdata_in, .reg_rdata_out, .cpu_stall_out, .chip_reset_out, .flash_addr_out, .flash_wdata_out,
  .flash_read_out, .flash_prog_out, .flash_erase_out, .flash_rdata_in, .flash_done_in);

// *** sim/fpc_ctrl_test.sv ***
// Self-checking bench for the flash program controller
`define CHK(act, exp) begin comparisons++; if ((act) !== (exp)) begin err_count++; \
  $display("[ERR] %0t got %h expected %h", $time, act, exp); end end
module fpc_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  import fpc_pkg::*;
  localparam int WIN = 20;
  localparam logic [7:0] KEY [6] = '{KEY_W1_LO, KEY_W2_LO, KEY_W3_LO, KEY_W1_HI, KEY_W2_HI, KEY_W3_HI};
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  logic [3:0]  reg_sel_in = 4'h0;
  logic [7:0]  reg_wdata_in = 8'h00;
  logic [7:0]  reg_rdata_out, rv;
  logic        cpu_stall_out, chip_reset_out, flash_read_out, flash_prog_out, flash_erase_out, flash_done_in;
  logic [14:0] flash_addr_out;
  logic [15:0] flash_wdata_out, flash_rdata_in, w;
  logic [3:0]  dly = 4'h0;
  logic [15:0] fmem [int];
  logic [15:0] bufm [int];
  int          err_count, comparisons, n_rst, n_prog, n_erase, n_read, a;

  fpc_ctrl #(.UNLOCK_WINDOW_CYCLES(WIN), .WORDS(PAGE_WORDS)) fpc_ctrl_inst (.clk_in, .rst_in, .reg_sel_in,
    .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out, .cpu_stall_out, .chip_reset_out, .flash_addr_out,
    .flash_wdata_out, .flash_read_out, .flash_prog_out, .flash_erase_out, .flash_rdata_in, .flash_done_in);
  fpc_flash_model fpc_flash_model_inst (.clk_in, .rst_in, .rd_in(flash_read_out), .prog_in(flash_prog_out),
    .erase_in(flash_erase_out), .addr_in(flash_addr_out), .wdata_in(flash_wdata_out), .delay_in(dly),
    .rdata_out(flash_rdata_in), .done_out(flash_done_in));

  always #4 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    if (chip_reset_out === 1'b1) n_rst++;
    if (flash_done_in === 1'b1) begin
      n_prog += int'(flash_prog_out);
      n_erase += int'(flash_erase_out);
      n_read += int'(flash_read_out);
    end
  end

  task automatic end_sim();
    if (err_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // A gap cycle after each access keeps strobes from being driven twice in one step
  task automatic wr(input logic [3:0] s, input logic [7:0] d);
    reg_sel_in = s;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(posedge clk_in) #1 reg_wr_in = 1'b0;
    @(posedge clk_in) #1;
  endtask
  task automatic rd(input logic [3:0] s);
    reg_sel_in = s;
    reg_rd_in = 1'b1;
    @(posedge clk_in) #1 rv = reg_rdata_out;
    reg_rd_in = 1'b0;
    @(posedge clk_in) #1;
  endtask
  task automatic idle();
    dly = 4'($urandom_range(6));
    for (int i = 0; i < 3000 && cpu_stall_out !== 1'b0; i++) @(posedge clk_in) #1;
    `CHK(cpu_stall_out, 1'b0)
  endtask
  task automatic setaddr(input int ad);
    wr(SEL_ADDR_LOW, 8'(ad));
    wr(SEL_ADDR_HIGH, 8'(ad >> 8));
  endtask
  task automatic load(input int idx);
    w = 16'($urandom);
    wr(SEL_DATA_BASE, w[7:0]);
    wr(SEL_DATA_BASE + 4'h1, w[15:8]);
    bufm[idx] = w;
  endtask
  task automatic fread(input int ad);
    setaddr(ad);
    wr(SEL_MAIN_CTRL, 8'hb2);
    wr(SEL_MAIN_CTRL, 8'hb3);
    idle();
    rd(SEL_DATA_BASE);
    w[7:0] = rv;
    rd(SEL_DATA_BASE + 4'h1);
    w[15:8] = rv;
    `CHK(w, fmem.exists(ad) ? fmem[ad] : 16'hffff)
  endtask
  task automatic unlock(input logic [7:0] bad);
    wr(SEL_MAIN_CTRL, 8'he0);
    wr(SEL_MAIN_CTRL, 8'he8);
    for (int k = 0; k < 6; k++) wr(4'(7 + 2 * (k % 3) + k / 3), KEY[k] ^ (k == 5 ? bad : 8'h00));
    rd(SEL_MAIN_CTRL);
    `CHK(rv[MC_UNLOCK_BIT], 1'b1)
    repeat (WIN) @(posedge clk_in) #1;
    rd(SEL_MAIN_CTRL);
    `CHK(rv[7:3], {bad == 8'h00, MODE_UNLOCK, 1'b0})
  endtask

  initial begin
    #400000;
    err_count++;
    end_sim();
  end

  initial begin
    void'($urandom(37134));
    repeat (12) @(posedge clk_in);
    #1 rst_in = 1'b0;
    for (int s = 0; s < 16; s++) begin
      rd(4'(s));
      `CHK(rv, 8'h00)
    end
    wr(SEL_CHIP_RESET_KEY, 8'h54);
    wr(SEL_CHIP_RESET_KEY, CHIP_RESET_VALUE);
    rd(SEL_CHIP_RESET_KEY);
    `CHK({rv, 8'(n_rst)}, {CHIP_RESET_VALUE, 8'h01})
    wr(SEL_MAIN_CTRL, 8'h80);
    rd(SEL_MAIN_CTRL);
    `CHK(rv, 8'h00)
    wr(SEL_MAIN_CTRL, 8'h14);
    idle();
    unlock(8'h01);
    unlock(8'h00);
    // Erase from a mid-page address still clears the whole page
    a = 128 * $urandom_range(255);
    setaddr(a + 5);
    wr(SEL_MAIN_CTRL, 8'h94);
    idle();
    for (int i = 0; i < 128; i++) fmem[a + i] = 16'h0000;
    `CHK(n_erase, 1)
    fread(a + 5);
    fread(a + 127);
    setaddr(a + 3);
    load(3);
    wr(SEL_BUF_CLEAR, 8'hff);
    rd(SEL_BUF_CLEAR);
    `CHK(rv, 8'h00)
    bufm.delete();
    setaddr(a + 124);
    wr(SEL_DATA_BASE, 8'h3c);
    rd(SEL_ADDR_LOW);
    `CHK(rv, 8'(a + 124))
    for (int j = 0; j < 6; j++) begin
      load(j > 3 ? 127 : 124 + j);
      rd(SEL_ADDR_LOW);
      `CHK(rv, 8'(a + (j > 2 ? 127 : 125 + j)))
    end
    wr(SEL_MAIN_CTRL, 8'h84);
    idle();
    `CHK(n_prog, 4)
    foreach (bufm[i]) fmem[a + i] = bufm[i];
    for (int i = 123; i < 128; i++) fread(a + i);
    wr(SEL_MAIN_CTRL, 8'h84);
    idle();
    `CHK(n_prog, 4)
    for (int m = 2; m < 8; m++) begin
      wr(SEL_MAIN_CTRL, {1'b1, 3'(m), 4'h4});
      idle();
    end
    `CHK({8'(n_prog), 8'(n_erase)}, 16'h0401)
    n_read = 0;
    wr(SEL_MAIN_CTRL, 8'hb1);
    idle();
    wr(SEL_MAIN_CTRL, 8'h82);
    wr(SEL_MAIN_CTRL, 8'h83);
    idle();
    `CHK(n_read, 0)
    wr(SEL_MAIN_CTRL, 8'h10);
    rd(SEL_MAIN_CTRL);
    `CHK(rv[MC_ENABLED_BIT], 1'b0)
    wr(SEL_MAIN_CTRL, 8'h14);
    idle();
    `CHK(n_erase, 1)
    fread(a + 126);
    end_sim();
  end
endmodule
